// ==== include/test_page_pkg.sv ====
// shared constants for the test and identification register page
package test_page_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [5:0] OFS_PROBE_BUS = 6'h35;
   localparam logic [5:0] OFS_SELF_CHECK = 6'h36;
   localparam logic [5:0] OFS_CHIP_ID = 6'h37;
   localparam logic [5:0] OFS_AUX_SRC = 6'h38;
   localparam logic [5:0] OFS_DAC_ONE = 6'h39;
   localparam logic [5:0] OFS_DAC_TWO = 6'h3A;
   // field positions
   localparam int SC_GAIN_BIT = 6;
   localparam int SC_FIELD_LSB = 0;
   localparam int AUX_ONE_LSB = 4;
   localparam int AUX_TWO_LSB = 0;
   localparam int ID_TYPE_LSB = 4;
   // reset values
   localparam logic [7:0] SELF_CHECK_RST = 8'h40;
   localparam logic [7:0] AUX_SRC_RST = 8'h00;
   localparam logic [5:0] DAC_RST = 6'h00;
   // self-check keys
   localparam logic [3:0] SC_ENABLE_KEY = 4'h9;
   localparam logic [3:0] SC_OFF_KEY = 4'h0;
   // identity codes, values arbitrary
   localparam logic [3:0] CHIP_TYPE_CODE = 4'h5;
   localparam logic [3:0] CHIP_REV_CODE = 4'h3;
   // aux pin source encodings
   localparam logic [3:0] SRC_TRISTATE = 4'h0;
   localparam logic [3:0] SRC_TEST_DAC = 4'h1;
   localparam logic [3:0] SRC_CORR = 4'h2;
   localparam logic [3:0] SRC_MIN_LEVEL = 4'h4;
   localparam logic [3:0] SRC_ADC_I = 4'h5;
   localparam logic [3:0] SRC_ADC_Q = 4'h6;
   localparam logic [3:0] SRC_HIGH = 4'hA;
   localparam logic [3:0] SRC_LOW = 4'hB;
   localparam logic [3:0] SRC_TX_ACT = 4'hC;
   localparam logic [3:0] SRC_RX_ACT = 4'hD;
   localparam logic [3:0] SRC_SUBCARRIER = 4'hE;
   localparam logic [3:0] SRC_PROBE_BIT = 4'hF;
   // analog route codes sent to the pad mux
   localparam logic [2:0] ROUTE_DIGITAL = 3'h0;
   localparam logic [2:0] ROUTE_DAC = 3'h1;
   localparam logic [2:0] ROUTE_CORR = 3'h2;
   localparam logic [2:0] ROUTE_MIN_LEVEL = 3'h3;
   localparam logic [2:0] ROUTE_ADC_I = 3'h4;
   localparam logic [2:0] ROUTE_ADC_Q = 3'h5;
   localparam logic [2:0] ROUTE_OFF = 3'h6;
endpackage

// ==== logic/aux_pin_mux.sv ====
// source selection for one auxiliary analog pin
`timescale 1ns/1ps
module aux_pin_mux
(
   // selector
   input wire logic [3:0] source_sel,
   // digital sources
   input wire logic tx_window,
   input wire logic rx_window,
   input wire logic subcarrier_seen,
   input wire logic probe_bit,
   // pad controls
   output logic pin_out,
   output logic pin_oe,
   output logic [2:0] analog_route
);
   // digital drive for the pin; analog routes leave oe low, the pad mux drives current
   wire is_high = source_sel == test_page_pkg::SRC_HIGH;
   wire is_low = source_sel == test_page_pkg::SRC_LOW;
   wire is_tx = source_sel == test_page_pkg::SRC_TX_ACT;
   wire is_rx = source_sel == test_page_pkg::SRC_RX_ACT;
   wire is_sc = source_sel == test_page_pkg::SRC_SUBCARRIER;
   wire is_pb = source_sel == test_page_pkg::SRC_PROBE_BIT;
   assign pin_oe = is_high | is_low | is_tx | is_rx | is_sc | is_pb; // [RULE7]
   assign pin_out = is_high | (is_tx & tx_window) | (is_rx & rx_window) // [RULE10] [RULE11]
      | (is_sc & subcarrier_seen) | (is_pb & probe_bit); // [RULE12] [RULE13]
   // analog route; reserved codes leave the pin floating
   assign analog_route =
      (source_sel == test_page_pkg::SRC_TEST_DAC) ? test_page_pkg::ROUTE_DAC : // [RULE8]
      (source_sel == test_page_pkg::SRC_CORR) ? test_page_pkg::ROUTE_CORR : // [RULE9]
      (source_sel == test_page_pkg::SRC_MIN_LEVEL) ? test_page_pkg::ROUTE_MIN_LEVEL :
      (source_sel == test_page_pkg::SRC_ADC_I) ? test_page_pkg::ROUTE_ADC_I :
      (source_sel == test_page_pkg::SRC_ADC_Q) ? test_page_pkg::ROUTE_ADC_Q :
      pin_oe ? test_page_pkg::ROUTE_DIGITAL : test_page_pkg::ROUTE_OFF;
endmodule // aux_pin_mux

// ==== logic/test_page_regs.sv ====
// test and identification register page with aux pin control
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
//
// Contract
// [RULE1] probe bus register reads live 8-bit probe bus chosen elsewhere.
// [RULE2] self-check enabled only when the 4-bit field holds 1001b.
// [RULE3] software writes 0000b to the field for normal operation.
// [RULE4] once enabled, checksum command starts the self-check sequence.
// [RULE5] gain bit 6 selects non-linear receive processing at 106 kBd.
// [RULE6] id register gives type in 7:4, revision in 3:0; read only.
// [RULE7] aux one selector in 7:4; 0000 tri-state, 1010 high, 1011 low.
// [RULE8] 0001 routes dac one to aux one, dac two to aux two.
// [RULE9] 0010 correlator, 0100 min level, 0101 adc i, 0110 adc q.
// [RULE10] 1100 outputs the transmit window flag.
// [RULE11] 1101 outputs the receive window flag.
// [RULE12] 1110 outputs subcarrier detected flag.
// [RULE13] 1111 outputs the probe bus bit picked by probe_bit_pick.
// [RULE14] aux two selector in 3:0 uses the same encoding.
// [RULE15] dac one register holds 6-bit value in 5:0.
// [RULE16] dac two register holds 6-bit value in 5:0.
// [RULE17] reserved bits ignore writes and read zero.
module test_page_regs
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // probe bus and bit pick, from the core on this clock
   input wire logic [7:0] probe_bus_value,
   input wire logic [2:0] probe_bit_pick,
   // status flags from the transceiver on this clock
   input wire logic transmit_window_flag,
   input wire logic receive_window_flag,
   input wire logic subcarrier_flag,
   input wire logic checksum_compute_cmd,
   // controls to the core
   output logic nonlinear_rx_gain,
   output logic self_check_enable,
   output logic self_check_start,
   output logic [5:0] probe_dac_one,
   output logic [5:0] probe_dac_two,
   // aux pins
   output logic analog_pin_one_out,
   output logic analog_pin_one_oe,
   output logic [2:0] analog_pin_one_route,
   output logic analog_pin_two_out,
   output logic analog_pin_two_oe,
   output logic [2:0] analog_pin_two_route
);
   logic gain_r;
   logic [3:0] check_field_r;
   logic [7:0] aux_src_r;
   logic [5:0] dac_one_r;
   logic [5:0] dac_two_r;
   logic [7:0] rdata_r;
   logic sc_en_r;
   logic sc_start_r;
   logic p1_out_r, p1_oe_r, p2_out_r, p2_oe_r;
   logic [2:0] p1_route_r, p2_route_r;

   // address decode
   wire wr_sc = reg_wr && reg_addr == test_page_pkg::OFS_SELF_CHECK;
   wire wr_aux = reg_wr && reg_addr == test_page_pkg::OFS_AUX_SRC;
   wire wr_d1 = reg_wr && reg_addr == test_page_pkg::OFS_DAC_ONE;
   wire wr_d2 = reg_wr && reg_addr == test_page_pkg::OFS_DAC_TWO;
   wire [3:0] aux_one_source = aux_src_r[test_page_pkg::AUX_ONE_LSB +: 4];
   wire [3:0] aux_two_source = aux_src_r[test_page_pkg::AUX_TWO_LSB +: 4];
   wire sc_enabled = check_field_r == test_page_pkg::SC_ENABLE_KEY; // [RULE2]
   wire probe_bit = probe_bus_value[probe_bit_pick]; // [RULE13]

   // read mux; reserved bits and unmapped offsets read zero
   wire [7:0] sc_view = {1'b0, gain_r, 2'b00, check_field_r}; // [RULE17]
   wire [7:0] id_view = {test_page_pkg::CHIP_TYPE_CODE, test_page_pkg::CHIP_REV_CODE}; // [RULE6]
   wire [7:0] rd_mux =
      (reg_addr == test_page_pkg::OFS_PROBE_BUS) ? probe_bus_value : // [RULE1]
      (reg_addr == test_page_pkg::OFS_SELF_CHECK) ? sc_view :
      (reg_addr == test_page_pkg::OFS_CHIP_ID) ? id_view :
      (reg_addr == test_page_pkg::OFS_AUX_SRC) ? aux_src_r :
      (reg_addr == test_page_pkg::OFS_DAC_ONE) ? {2'b00, dac_one_r} : // [RULE15]
      (reg_addr == test_page_pkg::OFS_DAC_TWO) ? {2'b00, dac_two_r} : 8'h00; // [RULE16]

   // per-pin source decoding, shared encoding
   wire p1_out, p1_oe, p2_out, p2_oe;
   wire [2:0] p1_route, p2_route;
   aux_pin_mux u_aux_one
   (
      .source_sel(aux_one_source),
      .tx_window(transmit_window_flag),
      .rx_window(receive_window_flag),
      .subcarrier_seen(subcarrier_flag),
      .probe_bit(probe_bit),
      .pin_out(p1_out),
      .pin_oe(p1_oe),
      .analog_route(p1_route)
   );
   aux_pin_mux u_aux_two
   (
      .source_sel(aux_two_source), // [RULE14]
      .tx_window(transmit_window_flag),
      .rx_window(receive_window_flag),
      .subcarrier_seen(subcarrier_flag),
      .probe_bit(probe_bit),
      .pin_out(p2_out),
      .pin_oe(p2_oe),
      .analog_route(p2_route)
   );

   // writable fields; only documented bits are stored
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         gain_r <= test_page_pkg::SELF_CHECK_RST[test_page_pkg::SC_GAIN_BIT];
         check_field_r <= test_page_pkg::SELF_CHECK_RST[3:0];
         aux_src_r <= test_page_pkg::AUX_SRC_RST;
         dac_one_r <= test_page_pkg::DAC_RST;
         dac_two_r <= test_page_pkg::DAC_RST;
      end
      else
      begin
         if (wr_sc)
         begin
            gain_r <= reg_wdata[test_page_pkg::SC_GAIN_BIT]; // [RULE5]
            check_field_r <= reg_wdata[3:0];
         end
         if (wr_aux)
            aux_src_r <= reg_wdata; // [RULE7]
         if (wr_d1)
            dac_one_r <= reg_wdata[5:0]; // [RULE15]
         if (wr_d2)
            dac_two_r <= reg_wdata[5:0]; // [RULE16]
      end
   end

   // registered outputs; one cycle of latency traded for glitch-free pads
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rdata_r <= 8'h00;
         sc_en_r <= 1'b0;
         sc_start_r <= 1'b0;
         p1_out_r <= 1'b0;
         p1_oe_r <= 1'b0;
         p1_route_r <= test_page_pkg::ROUTE_OFF;
         p2_out_r <= 1'b0;
         p2_oe_r <= 1'b0;
         p2_route_r <= test_page_pkg::ROUTE_OFF;
      end
      else
      begin
         rdata_r <= reg_rd ? rd_mux : 8'h00;
         sc_en_r <= sc_enabled;
         sc_start_r <= sc_enabled & checksum_compute_cmd; // [RULE4]
         p1_out_r <= p1_out;
         p1_oe_r <= p1_oe;
         p1_route_r <= p1_route;
         p2_out_r <= p2_out;
         p2_oe_r <= p2_oe;
         p2_route_r <= p2_route;
      end
   end

   assign reg_rdata = rdata_r;
   assign nonlinear_rx_gain = gain_r;
   assign self_check_enable = sc_en_r;
   assign self_check_start = sc_start_r;
   assign probe_dac_one = dac_one_r;
   assign probe_dac_two = dac_two_r;
   assign analog_pin_one_out = p1_out_r;
   assign analog_pin_one_oe = p1_oe_r;
   assign analog_pin_one_route = p1_route_r;
   assign analog_pin_two_out = p2_out_r;
   assign analog_pin_two_oe = p2_oe_r;
   assign analog_pin_two_route = p2_route_r;

   // checks
   a_probe_read: assert property (@(posedge clock) disable iff (sys_rst) // [RULE1]
      reg_rd && reg_addr == test_page_pkg::OFS_PROBE_BUS |=> reg_rdata == $past(probe_bus_value))
      else $error("probe bus read mismatch");
   a_check_enable: assert property (@(posedge clock) disable iff (sys_rst) // [RULE2]
      ##1 self_check_enable == ($past(check_field_r) == test_page_pkg::SC_ENABLE_KEY))
      else $error("self-check enable wrong");
   a_check_start: assert property (@(posedge clock) disable iff (sys_rst) // [RULE4]
      self_check_start |-> $past(checksum_compute_cmd) && $past(check_field_r) == 4'h9)
      else $error("self-check start without cause");
   a_gain_write: assert property (@(posedge clock) disable iff (sys_rst) // [RULE5]
      reg_wr && reg_addr == 6'h36 |=> nonlinear_rx_gain == $past(reg_wdata[6]))
      else $error("gain bit not written");
   a_id_read: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
      reg_rd && reg_addr == 6'h37 |=> reg_rdata == id_view)
      else $error("id read wrong");
   a_aux_high: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
      aux_one_source == 4'hA |=> analog_pin_one_oe && analog_pin_one_out)
      else $error("aux one not driven high");
   a_aux_tristate: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
      aux_two_source == 4'h0 |=> !analog_pin_two_oe && analog_pin_two_route == 3'h6)
      else $error("aux two not floating");
   a_aux_dac: assert property (@(posedge clock) disable iff (sys_rst) // [RULE8]
      aux_one_source == 4'h1 |=> analog_pin_one_route == 3'h1 && !analog_pin_one_oe)
      else $error("dac route wrong");
   a_aux_tx: assert property (@(posedge clock) disable iff (sys_rst) // [RULE10]
      aux_two_source == 4'hC |=> analog_pin_two_out == $past(transmit_window_flag))
      else $error("tx flag not on aux two");
   a_dac_reserved: assert property (@(posedge clock) disable iff (sys_rst) // [RULE17]
      reg_rd && reg_addr == 6'h39 |=> reg_rdata[7:6] == 2'b00)
      else $error("reserved dac bits nonzero");
   a_aux_corr: assert property (@(posedge clock) disable iff (sys_rst) // [RULE9]
      aux_one_source == 4'h2 |=> analog_pin_one_route == 3'h2 && !analog_pin_one_oe)
      else $error("correlator route wrong");
   a_aux_rx: assert property (@(posedge clock) disable iff (sys_rst) // [RULE11]
      aux_one_source == 4'hD |=> analog_pin_one_oe && analog_pin_one_out == $past(receive_window_flag))
      else $error("rx flag not on aux one");
   a_aux_subcarrier: assert property (@(posedge clock) disable iff (sys_rst) // [RULE12]
      aux_one_source == 4'hE |=> analog_pin_one_oe && analog_pin_one_out == $past(subcarrier_flag))
      else $error("subcarrier flag not on aux one");
   a_aux_probe_bit: assert property (@(posedge clock) disable iff (sys_rst) // [RULE13]
      aux_two_source == 4'hF |=> analog_pin_two_oe && analog_pin_two_out == $past(probe_bit))
      else $error("probe bit not on aux two");
   a_aux_two_low: assert property (@(posedge clock) disable iff (sys_rst) // [RULE14]
      aux_two_source == 4'hB |=> analog_pin_two_oe && !analog_pin_two_out)
      else $error("aux two not driven low");
   a_dac_one_write: assert property (@(posedge clock) disable iff (sys_rst) // [RULE15]
      reg_wr && reg_addr == 6'h39 |=> probe_dac_one == $past(reg_wdata[5:0]))
      else $error("dac one not written");
   a_dac_two_write: assert property (@(posedge clock) disable iff (sys_rst) // [RULE16]
      reg_wr && reg_addr == 6'h3A |=> probe_dac_two == $past(reg_wdata[5:0]))
      else $error("dac two not written");
   c_check_start: cover property (@(posedge clock) self_check_start);
   c_probe_bit: cover property (@(posedge clock) aux_one_source == 4'hF ##1 analog_pin_one_out);
   c_dac_two: cover property (@(posedge clock) reg_wr && reg_addr == 6'h3A);
   c_rx_flag: cover property (@(posedge clock) aux_two_source == 4'hD ##1 analog_pin_two_out);
endmodule // test_page_regs

// ==== sim/test_and_id_register_page_tb_top.sv ====
// self-checking bench for the test and identification register page
`timescale 1ns/1ps
module test_and_id_register_page_tb_top;
   logic clock, sys_rst, reg_wr, reg_rd, tx_f, rx_f, sub_f, cmd;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, probe_bus;
   logic [2:0] pick, route1, route2;
   logic gain, sc_en, sc_start, out1, oe1, out2, oe2;
   logic [5:0] dac1, dac2;
   int bad_count = 0;
   int compares = 0;
   // every input has a value at time zero
   initial
   begin
      {sys_rst, reg_wr, reg_rd, tx_f, rx_f, sub_f, cmd} = 7'h40;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
      probe_bus = 8'hA5;
      pick = 3'h0;
   end
   // 40 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   test_page_regs DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .probe_bus_value(probe_bus),
      .probe_bit_pick(pick), .transmit_window_flag(tx_f), .receive_window_flag(rx_f),
      .subcarrier_flag(sub_f), .checksum_compute_cmd(cmd), .nonlinear_rx_gain(gain),
      .self_check_enable(sc_en), .self_check_start(sc_start), .probe_dac_one(dac1), .probe_dac_two(dac2),
      .analog_pin_one_out(out1), .analog_pin_one_oe(oe1), .analog_pin_one_route(route1),
      .analog_pin_two_out(out2), .analog_pin_two_oe(oe2), .analog_pin_two_route(route2));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle strobes, launched just after an edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      // step off the edge so a following call never re-drives the strobe in this time step
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic cyc();
      @(posedge clock);
      #1;
   endtask
   // expected {oe, out, route}; out only matters while driving
   function automatic logic [4:0] aux_exp(input logic [3:0] c, input logic f);
      case (c)
         test_page_pkg::SRC_TEST_DAC: aux_exp = {2'b00, test_page_pkg::ROUTE_DAC};
         test_page_pkg::SRC_CORR: aux_exp = {2'b00, test_page_pkg::ROUTE_CORR};
         test_page_pkg::SRC_MIN_LEVEL: aux_exp = {2'b00, test_page_pkg::ROUTE_MIN_LEVEL};
         test_page_pkg::SRC_ADC_I: aux_exp = {2'b00, test_page_pkg::ROUTE_ADC_I};
         test_page_pkg::SRC_ADC_Q: aux_exp = {2'b00, test_page_pkg::ROUTE_ADC_Q};
         test_page_pkg::SRC_HIGH: aux_exp = {2'b11, test_page_pkg::ROUTE_DIGITAL};
         test_page_pkg::SRC_LOW: aux_exp = {2'b10, test_page_pkg::ROUTE_DIGITAL};
         test_page_pkg::SRC_TX_ACT, test_page_pkg::SRC_SUBCARRIER, test_page_pkg::SRC_PROBE_BIT:
            aux_exp = {1'b1, f, test_page_pkg::ROUTE_DIGITAL};
         test_page_pkg::SRC_RX_ACT: aux_exp = {1'b1, ~f, test_page_pkg::ROUTE_DIGITAL};
         default: aux_exp = {2'b00, test_page_pkg::ROUTE_OFF};
      endcase
   endfunction
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog: the tests need well under 1000 cycles
   initial
   begin
      #100us;
      bad_count++;
      finish_test();
   end
   initial
   begin
      logic [4:0] e;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      // reset values, id, unmapped offset
      rd(test_page_pkg::OFS_SELF_CHECK, test_page_pkg::SELF_CHECK_RST);
      chk(gain, 8'h01);
      rd(test_page_pkg::OFS_AUX_SRC, 8'h00);
      rd(test_page_pkg::OFS_DAC_ONE, 8'h00);
      rd(6'h3F, 8'h00);
      wr(test_page_pkg::OFS_CHIP_ID, 8'hFF);
      rd(test_page_pkg::OFS_CHIP_ID, {test_page_pkg::CHIP_TYPE_CODE, test_page_pkg::CHIP_REV_CODE});
      $display("reset and id test done");
      // live probe bus, changed between reads
      rd(test_page_pkg::OFS_PROBE_BUS, 8'hA5);
      probe_bus <= 8'h3C;
      rd(test_page_pkg::OFS_PROBE_BUS, 8'h3C);
      $display("probe bus test done");
      // self-check key, reserved bits, checksum command
      cmd <= 1'b1;
      cyc();
      cmd <= 1'b0;
      cyc();
      chk(sc_start, 8'h00);
      wr(test_page_pkg::OFS_SELF_CHECK, 8'hB9);
      rd(test_page_pkg::OFS_SELF_CHECK, 8'h09);
      chk({gain, sc_en}, 8'h01);
      cmd <= 1'b1;
      cyc();
      cmd <= 1'b0;
      chk(sc_start, 8'h01);
      cyc();
      chk(sc_start, 8'h00);
      wr(test_page_pkg::OFS_SELF_CHECK, 8'h48);
      cyc();
      chk({gain, sc_en}, 8'h02);
      wr(test_page_pkg::OFS_SELF_CHECK, {4'h4, test_page_pkg::SC_OFF_KEY});
      cyc();
      chk(sc_en, 8'h00);
      $display("self-check test done");
      // dac values, reserved bits dropped
      wr(test_page_pkg::OFS_DAC_ONE, 8'hFF);
      wr(test_page_pkg::OFS_DAC_TWO, 8'hEA);
      rd(test_page_pkg::OFS_DAC_ONE, 8'h3F);
      rd(test_page_pkg::OFS_DAC_TWO, 8'h2A);
      chk({dac1, 2'b00}, 8'hFC);
      chk({dac2, 2'b00}, 8'hA8);
      $display("dac test done");
      // every selector code on both pins, flags both ways
      for (int f = 0; f < 2; f++)
      begin
         tx_f <= f[0];
         rx_f <= ~f[0];
         sub_f <= f[0];
         probe_bus <= 8'hA5;
         pick <= {2'b00, ~f[0]};
         for (int c = 0; c < 16; c++)
         begin
            e = aux_exp(c[3:0], f[0]);
            wr(test_page_pkg::OFS_AUX_SRC, {c[3:0], c[3:0]});
            cyc();
            chk({3'b000, oe1, oe1 & out1, route1}, {3'b000, e[4], e[4] & e[3], e[2:0]});
            chk({3'b000, oe2, oe2 & out2, route2}, {3'b000, e[4], e[4] & e[3], e[2:0]});
         end
      end
      wr(test_page_pkg::OFS_AUX_SRC, 8'hA0);
      rd(test_page_pkg::OFS_AUX_SRC, 8'hA0);
      chk({oe1, out1, oe2}, 8'h06);
      $display("aux pin test done");
      finish_test();
   end
endmodule // test_and_id_register_page_tb_top
